// [hw/rpmc_pkg.sv]
// package of constants for the reset and power mode controller
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package rpmc_pkg;
	// register byte offsets
	localparam logic [7:0] CAUSE_OFS  = 8'h00;
	localparam logic [7:0] CONFIG_OFS = 8'h04;
	localparam logic [7:0] CTRL_OFS   = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0C;
	// reset cause flag positions
	localparam int CF_PIN   = 0;
	localparam int CF_WDT   = 1;
	localparam int CF_SW    = 2;
	localparam int CF_BREAK = 3;
	localparam int CF_BO    = 4;
	localparam int CF_POR   = 5;
	localparam int CF_W     = 6;
	localparam logic [5:0] CAUSE_POR_VAL = 6'h30;
	// config bit positions
	localparam int CB_BO_EN   = 0;
	localparam int CB_BO_IRQ  = 1;
	localparam int CB_RPE     = 2;
	localparam int CB_BRK_RST = 3;
	localparam int CB_CMP_OFF = 4;
	localparam int CB_RC_SYS  = 5;
	localparam int CB_TMR_EN  = 6;
	localparam int CFG_W      = 7;
	localparam logic [6:0] CONFIG_RST_VAL = 7'h01;
	// control bits: software reset and mode request field
	localparam int CT_SWRST   = 0;
	localparam int CT_MODE_LO = 1;
	// reset stretch after last request drops
	localparam int RST_HOLD_CYCLES = 8;
	localparam int HOLD_W = 4;

	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_IDLE,
		MODE_PDOWN,
		MODE_TOTAL
	} rpmc_mode_t;
endpackage

// [hw/rpmc_sync.sv]
// two flip-flop synchroniser with per-bit reset value
`timescale 1ns/1ps
module rpmc_sync #(
	parameter int              WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             CLK,
	input  wire logic             ARST_N,
	input  wire logic [WIDTH-1:0] D,
	output logic      [WIDTH-1:0] Q
);
	logic [WIDTH-1:0] meta;

	// meta feeds only the second stage
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			meta <= RESET_VAL;
			Q    <= RESET_VAL;
		end else begin
			meta <= D;
			Q    <= meta;
		end
	end
endmodule // rpmc_sync

// [hw/rpmc_top.sv]
// reset combiner, cause flags and power mode control with wishbone slave
`timescale 1ns/1ps
module rpmc_top #(
	parameter logic RPE_DEFAULT = 1'b0
) (
	input  wire logic        CLK,
	input  wire logic        ARST_N,
	// wishbone classic slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [31:0] WB_DAT_I,
	input  wire logic [3:0]  WB_SEL_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	// supply monitors, pin, reset sources and wake interrupts
	input  wire logic        POR_DETECT,
	input  wire logic        SUPPLY_LOW,
	input  wire logic        SHARED_RESET_PIN,
	input  wire logic        WDT_TIMEOUT,
	input  wire logic        UART_BREAK,
	input  wire logic        IRQ_PENDING,
	input  wire logic        WAKE_IRQ,
	// outputs
	output logic             SYS_RST_N,
	output logic             BROWNOUT_IRQ,
	output logic             PIN_INPUT,
	output logic             CPU_CLK_EN,
	output logic             PERIPH_CLK_EN,
	output logic             MAIN_OSC_EN,
	output logic             RC_OSC_EN,
	output logic             BROWNOUT_DET_EN,
	output logic             COMPARATOR_EN,
	output logic             WDT_RUN,
	output logic             SYSTIMER_RUN
);
	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [3:0] async_in;
	logic [3:0] sync_in;
	logic       por_s;
	logic       low_s;
	logic       pin_s;
	logic       wdt_s;

	assign async_in = {WDT_TIMEOUT, SHARED_RESET_PIN, SUPPLY_LOW, POR_DETECT};

	// pin idles high so reset release is not blocked by sync latency
	rpmc_sync #(
		.WIDTH     (4),
		.RESET_VAL (4'h4)
	) u_sync (
		.CLK    (CLK),
		.ARST_N (ARST_N),
		.D      (async_in),
		.Q      (sync_in)
	);

	assign por_s = sync_in[0];
	assign low_s = sync_in[1];
	assign pin_s = sync_in[2];
	assign wdt_s = sync_in[3];

	// ----------------------------------------------------------------
	// registers and bus decode
	// ----------------------------------------------------------------
	logic [rpmc_pkg::CF_W-1:0]  cause;
	logic [rpmc_pkg::CF_W-1:0]  next_cause;
	logic [rpmc_pkg::CFG_W-1:0] config_r;
	logic                       ack;
	logic [31:0]                rdata;
	logic [31:0]                next_rdata;
	logic                       bus_req;
	logic                       bus_wr;
	logic                       lane0;
	logic                       hit_cause;
	logic                       hit_config;
	logic                       hit_ctrl;
	logic                       hit_status;
	logic                       wr_cause;
	logic                       wr_config;
	logic                       wr_ctrl;
	logic                       sw_reset;
	logic [1:0]                 mode_req;

	assign bus_req    = WB_CYC_I & WB_STB_I;
	// writes land on the edge that also sees ack high
	assign bus_wr     = bus_req & WB_WE_I & ack;
	assign lane0      = WB_SEL_I[0];
	assign hit_cause  = WB_ADR_I == rpmc_pkg::CAUSE_OFS;
	assign hit_config = WB_ADR_I == rpmc_pkg::CONFIG_OFS;
	assign hit_ctrl   = WB_ADR_I == rpmc_pkg::CTRL_OFS;
	assign hit_status = WB_ADR_I == rpmc_pkg::STATUS_OFS;
	assign wr_cause   = bus_wr & lane0 & hit_cause;
	assign wr_config  = bus_wr & lane0 & hit_config;
	assign wr_ctrl    = bus_wr & lane0 & hit_ctrl;
	assign sw_reset   = wr_ctrl & WB_DAT_I[rpmc_pkg::CT_SWRST];
	assign mode_req   = WB_DAT_I[rpmc_pkg::CT_MODE_LO +: 2];

	// ----------------------------------------------------------------
	// brownout and reset requests
	// ----------------------------------------------------------------
	rpmc_pkg::rpmc_mode_t mode;
	rpmc_pkg::rpmc_mode_t next_mode;
	logic                 powerup;
	logic                 bo_active;
	logic                 bo_cond;
	logic                 pin_is_reset;
	logic                 pin_rst;
	logic                 bo_rst;
	logic                 brk_rst;
	logic                 req_any;
	logic [5:0]           src_set;
	logic [rpmc_pkg::HOLD_W-1:0] hold;
	logic [rpmc_pkg::HOLD_W-1:0] next_hold;
	logic                 hold_done;

	// detector is off in total power-down
	assign bo_active = config_r[rpmc_pkg::CB_BO_EN] & (mode != rpmc_pkg::MODE_TOTAL);
	assign bo_cond   = bo_active & low_s;
	assign bo_rst    = bo_cond & ~config_r[rpmc_pkg::CB_BO_IRQ];
	assign BROWNOUT_IRQ = bo_cond & config_r[rpmc_pkg::CB_BO_IRQ];

	// power-up forces pin to reset use; otherwise the RPE bit decides
	assign pin_is_reset = config_r[rpmc_pkg::CB_RPE] | powerup;
	assign pin_rst      = pin_is_reset & ~pin_s;
	assign PIN_INPUT    = pin_is_reset ? 1'b1 : pin_s;
	assign brk_rst      = UART_BREAK & config_r[rpmc_pkg::CB_BRK_RST];

	assign req_any = por_s | pin_rst | bo_rst | wdt_s | sw_reset | brk_rst;

	always_comb begin
		src_set = '0;
		src_set[rpmc_pkg::CF_PIN]   = pin_rst;
		src_set[rpmc_pkg::CF_WDT]   = wdt_s;
		src_set[rpmc_pkg::CF_SW]    = sw_reset;
		src_set[rpmc_pkg::CF_BREAK] = brk_rst;
		src_set[rpmc_pkg::CF_BO]    = bo_rst;
		src_set[rpmc_pkg::CF_POR]   = 1'b0;
	end

	// software clear is write-zero; a set in the same cycle wins
	always_comb begin
		next_cause = (wr_cause ? cause & WB_DAT_I[rpmc_pkg::CF_W-1:0] : cause) | src_set;
		if (por_s) begin
			next_cause = rpmc_pkg::CAUSE_POR_VAL;
		end
	end

	// ----------------------------------------------------------------
	// reset stretch and synchronous release
	// ----------------------------------------------------------------
	assign hold_done = (hold == '0) & ~req_any;

	always_comb begin
		next_hold = hold;
		if (req_any) begin
			next_hold = rpmc_pkg::HOLD_W'(rpmc_pkg::RST_HOLD_CYCLES);
		end else if (hold != '0) begin
			next_hold = hold - 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			hold      <= rpmc_pkg::HOLD_W'(rpmc_pkg::RST_HOLD_CYCLES);
			SYS_RST_N <= 1'b0;
			powerup   <= 1'b1;
		end else begin
			hold      <= next_hold;
			SYS_RST_N <= hold_done;
			// a held pin keeps power-up alive: the board must let go
			powerup   <= por_s | (powerup & ~hold_done);
		end
	end

	// ----------------------------------------------------------------
	// power mode state
	// ----------------------------------------------------------------
	always_comb begin
		next_mode = mode;
		unique case (mode)
			rpmc_pkg::MODE_RUN: begin
				if (wr_ctrl & ~sw_reset) begin
					next_mode = rpmc_pkg::rpmc_mode_t'(mode_req);
				end
			end
			rpmc_pkg::MODE_IDLE: begin
				if (IRQ_PENDING) begin
					next_mode = rpmc_pkg::MODE_RUN;
				end
			end
			rpmc_pkg::MODE_PDOWN,
			rpmc_pkg::MODE_TOTAL: begin
				if (WAKE_IRQ) begin
					next_mode = rpmc_pkg::MODE_RUN;
				end
			end
		endcase
		// any reset ends every low power mode
		if (req_any) begin
			next_mode = rpmc_pkg::MODE_RUN;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			mode <= rpmc_pkg::MODE_RUN;
		end else begin
			mode <= next_mode;
		end
	end

	// ----------------------------------------------------------------
	// clock and block enables per mode
	// ----------------------------------------------------------------
	logic in_pd;
	logic rc_keep;

	assign in_pd   = (mode == rpmc_pkg::MODE_PDOWN) | (mode == rpmc_pkg::MODE_TOTAL);
	assign rc_keep = config_r[rpmc_pkg::CB_RC_SYS] & config_r[rpmc_pkg::CB_TMR_EN];

	assign CPU_CLK_EN      = mode == rpmc_pkg::MODE_RUN;
	assign PERIPH_CLK_EN   = ~in_pd;
	assign MAIN_OSC_EN     = ~in_pd;
	assign RC_OSC_EN       = ~in_pd | rc_keep;
	assign BROWNOUT_DET_EN = bo_active;
	assign COMPARATOR_EN   = ~config_r[rpmc_pkg::CB_CMP_OFF] & (mode != rpmc_pkg::MODE_TOTAL);
	assign WDT_RUN         = 1'b1;
	assign SYSTIMER_RUN    = config_r[rpmc_pkg::CB_TMR_EN];

	// ----------------------------------------------------------------
	// register storage and bus answer
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (hit_cause) begin
			next_rdata = {26'h0, cause};
		end else if (hit_config) begin
			next_rdata = {25'h0, config_r};
		end else if (hit_ctrl) begin
			next_rdata = {29'h0, mode, 1'b0};
		end else if (hit_status) begin
			next_rdata = {27'h0, pin_s, low_s, bo_cond, SYS_RST_N, powerup};
		end
	end

	// cause and config survive internal resets; ARST_N reloads both, POR_DETECT reloads only cause
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cause <= rpmc_pkg::CAUSE_POR_VAL;
		end else begin
			cause <= next_cause;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			config_r <= rpmc_pkg::CONFIG_RST_VAL;
			config_r[rpmc_pkg::CB_RPE] <= RPE_DEFAULT;
		end else if (wr_config) begin
			config_r <= WB_DAT_I[rpmc_pkg::CFG_W-1:0];
		end
	end

	// one wait state: ack follows the request by one edge
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ack   <= 1'b0;
			rdata <= 32'h0000_0000;
		end else begin
			ack   <= bus_req & ~ack;
			rdata <= next_rdata;
		end
	end

	assign WB_ACK_O = ack;
	assign WB_DAT_O = rdata;
endmodule // rpmc_top

// [tb/rpmc_supply_model.sv]
// supply monitors and external reset circuit
`timescale 1ns/1ps
module rpmc_supply_model (
	input  wire logic por_cmd,
	input  wire logic low_cmd,
	input  wire logic pin_cmd,
	output logic      por_detect,
	output logic      supply_low,
	output logic      pin
);
	// ----------------
	// monitors and pin
	// ----------------
	// pin has a pull-up; never held low while power comes up
	assign pin        = ~(pin_cmd & ~por_cmd);
	assign por_detect = por_cmd;
	assign supply_low = low_cmd;
endmodule // rpmc_supply_model

// [tb/rpmc_top_properties.sv]
// assertions on the reset and power mode controller ports
`timescale 1ns/1ps
module rpmc_top_properties (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_ACK_O,
	input wire logic WDT_TIMEOUT,
	input wire logic IRQ_PENDING,
	input wire logic SYS_RST_N,
	input wire logic BROWNOUT_IRQ,
	input wire logic BROWNOUT_DET_EN,
	input wire logic PIN_INPUT,
	input wire logic CPU_CLK_EN,
	input wire logic MAIN_OSC_EN,
	input wire logic WDT_RUN
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	// ----------------
	// port relations
	// ----------------
	a_wdt_reset: assert property ($rose(WDT_TIMEOUT) |-> ##[1:4] !SYS_RST_N)
		else $error("watchdog request gave no reset");
	// low time is at least the stretch, so short requests still reset fully
	a_reset_stretch: assert property ($fell(SYS_RST_N) |=> !SYS_RST_N [*7])
		else $error("reset released too early");
	a_reset_run: assert property ($fell(SYS_RST_N) |-> ##2 (CPU_CLK_EN && MAIN_OSC_EN))
		else $error("reset did not end low power mode");
	a_idle_wake: assert property (IRQ_PENDING && !CPU_CLK_EN && MAIN_OSC_EN |-> ##[1:2] CPU_CLK_EN)
		else $error("interrupt did not end idle");
	a_pdown_wdt: assert property (!MAIN_OSC_EN |-> WDT_RUN && !CPU_CLK_EN)
		else $error("watchdog stopped in power-down");
	a_irq_needs_det: assert property (BROWNOUT_IRQ |-> BROWNOUT_DET_EN)
		else $error("brownout interrupt with detector off");
	a_pin_plain: assert property (!PIN_INPUT |-> SYS_RST_N)
		else $error("plain input pin caused reset");
	a_ack_once: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("bus request not answered");
	cover property ($fell(SYS_RST_N));
	cover property (BROWNOUT_IRQ);
	cover property (!MAIN_OSC_EN && !BROWNOUT_DET_EN);
endmodule // rpmc_top_properties

// [tb/tb.sv]
// self-checking bench of the reset and power mode controller
`timescale 1ns/1ps
module tb;
	logic        CLK = 1'b0, ARST_N = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
	logic [7:0]  WB_ADR_I = 8'h00;
	logic [31:0] WB_DAT_I = 32'h0, q;
	logic [3:0]  WB_SEL_I = 4'hF;
	logic        WDT_TIMEOUT = 1'b0, UART_BREAK = 1'b0, IRQ_PENDING = 1'b0, WAKE_IRQ = 1'b0;
	logic        por_cmd = 1'b0, low_cmd = 1'b0, pin_cmd = 1'b0;
	wire  [31:0] WB_DAT_O;
	wire         WB_ACK_O, POR_DETECT, SUPPLY_LOW, SHARED_RESET_PIN, SYS_RST_N, BROWNOUT_IRQ, PIN_INPUT;
	wire         CPU_CLK_EN, PERIPH_CLK_EN, MAIN_OSC_EN, RC_OSC_EN, BROWNOUT_DET_EN, COMPARATOR_EN;
	wire         WDT_RUN, SYSTIMER_RUN;
	wire  [6:0]  outs = {CPU_CLK_EN, MAIN_OSC_EN, RC_OSC_EN, BROWNOUT_DET_EN, COMPARATOR_EN, WDT_RUN, SYSTIMER_RUN};
	int          errors = 0, checks_done = 0, cycles = 0, n;
	logic [31:0] cause_tab [5] = '{32'h02, 32'h0A, 32'h1A, 32'h1B, 32'h30};
	logic [31:0] cfg_tab [4] = '{32'h61, 32'h61, 32'h61, 32'h21};
	logic [1:0]  mode_tab [4] = '{2'd1, 2'd2, 2'd3, 2'd2};
	logic [6:0]  exp_tab [4] = '{7'h3F, 7'h1F, 7'h13, 7'h0E};
	rpmc_top rpmc_top_i (.*);
	rpmc_supply_model rpmc_supply_model_i (.por_cmd(por_cmd), .low_cmd(low_cmd), .pin_cmd(pin_cmd),
		.por_detect(POR_DETECT), .supply_low(SUPPLY_LOW), .pin(SHARED_RESET_PIN));
	always #2 CLK = ~CLK;
	// ----------------
	// tasks
	// ----------------
	task check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task results;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		WB_CYC_I <= 1'b1;
		WB_STB_I <= 1'b1;
		WB_WE_I  <= we;
		WB_ADR_I <= a;
		WB_DAT_I <= d;
		@(posedge CLK);
		while (WB_ACK_O !== 1'b1) @(posedge CLK);
		q = WB_DAT_O;
		WB_CYC_I <= 1'b0;
		WB_STB_I <= 1'b0;
		@(posedge CLK);
	endtask
	task fall;
		for (n = 0; n < 40 && SYS_RST_N !== 1'b0; n++) @(posedge CLK);
	endtask
	task rise;
		for (n = 0; n < 60 && SYS_RST_N !== 1'b1; n++) @(posedge CLK);
	endtask
	task src(input int k, input logic v);
		case (k)
			0: WDT_TIMEOUT <= v;
			1: UART_BREAK <= v;
			2: low_cmd <= v;
			3: pin_cmd <= v;
			default: por_cmd <= v;
		endcase
	endtask
	// one reset source held until the merged reset is seen
	task hit(input int k);
		src(k, 1'b1);
		fall();
		src(k, 1'b0);
		rise();
	endtask
	// ----------------
	// sequence
	// ----------------
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			results();
		end
	end
	initial begin
		repeat (8) @(posedge CLK);
		ARST_N <= 1'b1;
		rise();
		wb(0, rpmc_pkg::CAUSE_OFS, 0);
		check(q, 32'h30);
		wb(0, rpmc_pkg::CONFIG_OFS, 0);
		check(q, 32'h01);
		wb(1, rpmc_pkg::CAUSE_OFS, 32'h10);
		wb(0, rpmc_pkg::CAUSE_OFS, 0);
		check(q, 32'h10);
		wb(1, rpmc_pkg::CTRL_OFS, 32'h1);
		fall();
		rise();
		wb(0, rpmc_pkg::CAUSE_OFS, 0);
		check(q, 32'h14);
		// pin reset on, as fast clocks need it
		wb(1, rpmc_pkg::CONFIG_OFS, 32'h0D);
		wb(1, rpmc_pkg::CAUSE_OFS, 32'h0);
		for (int k = 0; k < 5; k++) begin
			hit(k);
			wb(0, rpmc_pkg::CAUSE_OFS, 0);
			check(q, cause_tab[k]);
		end
		wb(1, rpmc_pkg::CONFIG_OFS, 32'h03);
		src(2, 1'b1);
		repeat (4) @(posedge CLK);
		check({BROWNOUT_IRQ, SYS_RST_N}, 2'b11);
		src(2, 1'b0);
		repeat (4) @(posedge CLK);
		check(BROWNOUT_IRQ, 0);
		wb(1, rpmc_pkg::CONFIG_OFS, 32'h02);
		src(2, 1'b1);
		src(3, 1'b1);
		repeat (4) @(posedge CLK);
		check({BROWNOUT_IRQ, PIN_INPUT, SYS_RST_N}, 3'b001);
		src(2, 1'b0);
		src(3, 1'b0);
		for (int k = 0; k < 4; k++) begin
			wb(1, rpmc_pkg::CONFIG_OFS, cfg_tab[k]);
			wb(1, rpmc_pkg::CTRL_OFS, {29'h0, mode_tab[k], 1'b0});
			repeat (2) @(posedge CLK);
			check(outs, exp_tab[k]);
			if (k == 0) check(PERIPH_CLK_EN, 1);
			if (k != 0) check(PERIPH_CLK_EN, 0);
			if (k == 0) IRQ_PENDING <= 1'b1;
			else WAKE_IRQ <= 1'b1;
			@(posedge CLK);
			IRQ_PENDING <= 1'b0;
			WAKE_IRQ <= 1'b0;
			repeat (2) @(posedge CLK);
			check({CPU_CLK_EN, MAIN_OSC_EN}, 2'b11);
		end
		// total power-down is also left by a reset, here a watchdog request
		wb(1, rpmc_pkg::CTRL_OFS, {29'h0, 2'd3, 1'b0});
		hit(0);
		check({CPU_CLK_EN, MAIN_OSC_EN}, 2'b11);
		wb(0, rpmc_pkg::STATUS_OFS, 0);
		check(q, 32'h12);
		wb(0, 8'h10, 0);
		check(q, 0);
		results();
	end
endmodule // tb
bind rpmc_top rpmc_top_properties rpmc_top_properties_i (.*);
